// [core/bra_pkg.sv]
// package for the backplane round-robin arbiter and its master end
// assumes one core clock domain shared by arbiter, interface and masters
package bra_pkg;
	// ========================================
	// chassis sizes
	localparam int unsigned SLOTS_LARGE   = 7;
	localparam int unsigned SLOTS_SMALL   = 5;
	localparam int unsigned CPUS_LARGE    = 5;
	localparam int unsigned CPUS_SMALL    = 3;
	localparam int unsigned MAX_SLOTS     = SLOTS_LARGE;
	// ========================================
	// owner bus widths
	localparam int unsigned ADDR_W        = 32;
	localparam int unsigned SPACE_W       = 4;
	localparam int unsigned DATA_W        = 64;
	localparam int unsigned CHECK_W       = 8;
	localparam int unsigned TID_W         = 8;
	localparam int unsigned TTYPE_W       = 5;
	localparam int unsigned SLOT_W        = 3;
	// ========================================
	// pointer reset value and step
	localparam logic [SLOT_W-1:0] PTR_RST = 3'h0;
	localparam logic [SLOT_W-1:0] PTR_STEP = 3'h1;
	// ========================================
	// arbiter states
	typedef enum logic [0:0] {
		BRA_IDLE = 1'b0,
		BRA_OWN  = 1'b1
	} bra_arb_state_t;
	// master end states
	typedef enum logic [1:0] {
		BRA_M_IDLE = 2'b00,
		BRA_M_REQ  = 2'b01,
		BRA_M_XFER = 2'b10
	} bra_mst_state_t;
endpackage

// [core/bra_bus_if.sv]
// interface joining the arbiter and the master boards of the backplane
// assumes all parties run on core_clk; owner buses muxed by the bench
`timescale 1ns/10ps
interface bra_bus_if #(
	parameter int unsigned N_SLOTS = bra_pkg::MAX_SLOTS
);
	logic [N_SLOTS-1:0]                 slot_req;
	logic [N_SLOTS-1:0]                 slot_grant;
	logic [bra_pkg::ADDR_W-1:0]         bus_address_lines;
	logic [bra_pkg::SPACE_W-1:0]        space_select_lines;
	logic [bra_pkg::DATA_W-1:0]         bus_data_lines;
	logic [bra_pkg::CHECK_W-1:0]        check_byte_lines;
	logic [bra_pkg::TID_W-1:0]          transaction_id_lines;
	logic [bra_pkg::TTYPE_W-1:0]        transaction_type_lines;
	logic                               bus_valid;

	modport arbiter (
		input  slot_req,
		output slot_grant
	);
	modport master (
		output slot_req,
		input  slot_grant,
		output bus_address_lines,
		output space_select_lines,
		output bus_data_lines,
		output check_byte_lines,
		output transaction_id_lines,
		output transaction_type_lines,
		output bus_valid
	);
endinterface

// [core/bra_rr_pick.sv]
// round-robin picker: first request at or after the pointer, wrapping
// assumes purely combinational use inside the arbiter
`timescale 1ns/10ps
module bra_rr_pick #(
	parameter int unsigned N = bra_pkg::MAX_SLOTS
) (
	// inputs
	input  wire logic [N-1:0]               req,
	input  wire logic [bra_pkg::SLOT_W-1:0] start,
	// result
	output logic                            found,
	output logic [bra_pkg::SLOT_W-1:0]      pick
);
	function automatic logic [bra_pkg::SLOT_W-1:0] wrap_add(
		input logic [bra_pkg::SLOT_W-1:0] a,
		input int unsigned                b
	);
		int unsigned s;
		s = (int'(a) + b) % N;
		return bra_pkg::SLOT_W'(s);
	endfunction

	always_comb begin
		logic [bra_pkg::SLOT_W-1:0] idx;
		idx   = '0;
		found = 1'b0;
		pick  = '0;
		// scan from highest offset down so the nearest wins
		for (int unsigned k = N; k > 0; k--) begin
			idx = wrap_add(start, k - 1);
			if (req[idx]) begin
				found = 1'b1;
				pick  = idx;
			end
		end
	end
endmodule // bra_rr_pick

// [core/bra_arbiter.sv]
// backplane round-robin arbiter: one grant line per board slot
// assumes requests arrive from logic on core_clk, held through each transfer
// ========================================
// Behaviour
// R1: masters raise own request line, not bus
// R2: rotating round-robin among simultaneous requesters
// R3: at most one grant at any time
// R4: master waits for grant before transferring
// R5: only masters begin transactions
// R6: serves seven slots, or five small chassis
// R7: five processor boards large, three small
// R8: hub requests only for own transactions
// R9: memory and graphics never request
// R10: owner drives address, space, data, check, id, type
// R11: pointer moves past last granted slot
// R12: reset clears grants; grant held while requested
`timescale 1ns/10ps
module bra_arbiter #(
	parameter int unsigned N_SLOTS = bra_pkg::SLOTS_LARGE
) (
	// clock and reset
	input  wire logic      core_clk,
	input  wire logic      rst_n,
	// chassis size select
	input  wire logic      small_chassis,
	// backplane
	bra_bus_if.arbiter     bus,
	// status
	output logic           busy_ff,
	output logic [bra_pkg::SLOT_W-1:0] owner_ff
);
	bra_pkg::bra_arb_state_t           state_ff;
	bra_pkg::bra_arb_state_t           nxt_state;
	logic [bra_pkg::SLOT_W-1:0]        ptr_ff;
	logic [N_SLOTS-1:0]                grant_ff;
	logic [N_SLOTS-1:0]                slot_mask;
	logic [N_SLOTS-1:0]                live_req;
	logic                              found;
	logic [bra_pkg::SLOT_W-1:0]        pick;
	logic                              owner_req;
	logic                              take_now;
	logic                              release_now;

	// ========================================
	// helpers
	// one-hot line of a slot; also picks out the owner's request bit
	function automatic logic [N_SLOTS-1:0] slot_line(
		input logic [bra_pkg::SLOT_W-1:0] slot
	);
		logic [N_SLOTS-1:0] line;
		line = '0;
		for (int unsigned i = 0; i < N_SLOTS; i++) begin
			if (slot == bra_pkg::SLOT_W'(i)) begin
				line[i] = 1'b1;
			end
		end
		return line;
	endfunction

	// search start after a slot; wraps at the last slot, not at the power of two
	function automatic logic [bra_pkg::SLOT_W-1:0] slot_after(
		input logic [bra_pkg::SLOT_W-1:0] slot
	);
		logic [bra_pkg::SLOT_W-1:0] nxt_slot;
		if (int'(slot) == N_SLOTS - 1) begin
			nxt_slot = bra_pkg::PTR_RST;
		end else begin
			nxt_slot = slot + bra_pkg::PTR_STEP;
		end
		return nxt_slot;
	endfunction

	// ========================================
	// eligible requests
	// slots beyond the small chassis are never populated there
	always_comb begin
		for (int unsigned i = 0; i < N_SLOTS; i++) begin
			slot_mask[i] = !small_chassis || (i < bra_pkg::SLOTS_SMALL); // [R6] [R7]
		end
	end
	assign live_req    = bus.slot_req & slot_mask; // [R1]
	assign owner_req   = |(live_req & slot_line(owner_ff));
	// a masked-off owner counts as released, so a chassis switch cannot hang the bus
	assign take_now    = (state_ff == bra_pkg::BRA_IDLE) && found;
	assign release_now = (state_ff == bra_pkg::BRA_OWN) && !owner_req; // [R12]

	bra_rr_pick #(
		.N     (N_SLOTS)
	) u_pick (
		.req   (live_req),
		.start (ptr_ff), // [R2]
		.found (found),
		.pick  (pick)
	);

	// ========================================
	// state
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			bra_pkg::BRA_IDLE: begin
				if (take_now) begin
					nxt_state = bra_pkg::BRA_OWN;
				end
			end
			bra_pkg::BRA_OWN: begin
				if (release_now) begin
					nxt_state = bra_pkg::BRA_IDLE; // [R12]
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= bra_pkg::BRA_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ========================================
	// grant: one-hot, a dead cycle between owners so lines never overlap
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			grant_ff <= '0; // [R12]
		end else if (take_now) begin
			grant_ff <= slot_line(pick); // [R3]
		end else if (release_now) begin
			grant_ff <= '0; // [R3] [R12]
		end
	end
	assign bus.slot_grant = grant_ff;

	// ========================================
	// owner: kept after release so status shows the last holder
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			owner_ff <= bra_pkg::PTR_RST; // [R12]
		end else if (take_now) begin
			owner_ff <= pick;
		end
	end

	// ========================================
	// busy
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_ff <= 1'b0;
		end else if (take_now) begin
			busy_ff <= 1'b1;
		end else if (release_now) begin
			busy_ff <= 1'b0;
		end
	end

	// ========================================
	// pointer
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ptr_ff <= bra_pkg::PTR_RST; // [R12]
		end else if (release_now) begin
			ptr_ff <= slot_after(owner_ff); // [R11]
		end
	end
endmodule // bra_arbiter

// [core/bra_master.sv]
// master board end: requests ownership, then drives one transfer
// assumes user holds cmd fields stable from cmd_valid until cmd_done
`timescale 1ns/10ps
module bra_master #(
	parameter int unsigned N_SLOTS = bra_pkg::SLOTS_LARGE,
	parameter int unsigned SLOT    = 0
) (
	// clock and reset
	input  wire logic                          core_clk,
	input  wire logic                          rst_n,
	// user command
	input  wire logic                          cmd_valid,
	input  wire logic [bra_pkg::ADDR_W-1:0]    cmd_addr,
	input  wire logic [bra_pkg::SPACE_W-1:0]   cmd_space,
	input  wire logic [bra_pkg::DATA_W-1:0]    cmd_data,
	input  wire logic [bra_pkg::CHECK_W-1:0]   cmd_check,
	input  wire logic [bra_pkg::TID_W-1:0]     cmd_tid,
	input  wire logic [bra_pkg::TTYPE_W-1:0]   cmd_ttype,
	output logic                               cmd_done_ff,
	// backplane
	bra_bus_if.master                          bus
);
	bra_pkg::bra_mst_state_t state_ff;
	logic                    req_ff;
	logic                    drive_ff;

	// only this end starts transfers; slave boards have no such module
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff    <= bra_pkg::BRA_M_IDLE;
			req_ff      <= 1'b0;
			drive_ff    <= 1'b0;
			cmd_done_ff <= 1'b0;
		end else begin
			cmd_done_ff <= 1'b0;
			unique case (state_ff)
				bra_pkg::BRA_M_IDLE: begin
					if (cmd_valid) begin
						req_ff   <= 1'b1; // [R1] [R5] [R8]
						state_ff <= bra_pkg::BRA_M_REQ;
					end
				end
				bra_pkg::BRA_M_REQ: begin
					if (bus.slot_grant[SLOT]) begin
						drive_ff <= 1'b1; // [R4]
						state_ff <= bra_pkg::BRA_M_XFER;
					end
				end
				bra_pkg::BRA_M_XFER: begin
					// one beat, then release so the next owner can rotate in
					drive_ff    <= 1'b0;
					req_ff      <= 1'b0; // [R12]
					cmd_done_ff <= 1'b1;
					state_ff    <= bra_pkg::BRA_M_IDLE;
				end
				default: begin
					state_ff <= bra_pkg::BRA_M_IDLE;
				end
			endcase
		end
	end

	always_comb begin
		bus.slot_req       = '0;
		bus.slot_req[SLOT] = req_ff;
	end
	// idle owner lines rest at zero so the bench can or them together
	assign bus.bus_valid              = drive_ff; // [R10]
	assign bus.bus_address_lines      = drive_ff ? cmd_addr  : '0;
	assign bus.space_select_lines     = drive_ff ? cmd_space : '0;
	assign bus.bus_data_lines         = drive_ff ? cmd_data  : '0;
	assign bus.check_byte_lines       = drive_ff ? cmd_check : '0;
	assign bus.transaction_id_lines   = drive_ff ? cmd_tid   : '0;
	assign bus.transaction_type_lines = drive_ff ? cmd_ttype : '0;
endmodule // bra_master

// [test/bra_properties.sv]
// checker for grant and owner beat timing on the merged backplane
// assumes the interface signals of one core_clk domain, seven slots
`timescale 1ns/10ps
module bra_properties (
	// clock and reset
	input wire logic       core_clk,
	input wire logic       rst_n,
	// backplane
	input wire logic [6:0] slot_req,
	input wire logic [6:0] slot_grant,
	input wire logic       bus_valid
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// ========================================
	// last owner, for the rotation check
	logic [6:0] last_ff;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			last_ff <= 7'h00;
		else if (slot_grant != 7'h00)
			last_ff <= slot_grant;
	end
	// ========================================
	// properties
	one_grant_a: assert property ($onehot0(slot_grant))
		else $error("more than one grant");
	// slots 5 and 6 may be masked by the chassis select, so only 0..4 here
	grant_answer_a: assert property (slot_grant == 7'h00 && slot_req[4:0] != 5'h00
		|=> slot_grant != 7'h00) else $error("idle request not granted");
	hold_grant_a: assert property ((slot_grant & slot_req) != 7'h00 |=> $stable(slot_grant))
		else $error("grant moved while owner requests");
	drop_grant_a: assert property (slot_grant != 7'h00 && (slot_grant & slot_req) == 7'h00
		|=> slot_grant == 7'h00) else $error("grant kept after release");
	valid_owner_a: assert property (bus_valid |-> (slot_grant & $past(slot_grant)) != 7'h00)
		else $error("beat without standing grant");
	one_beat_a: assert property (bus_valid |=> !bus_valid && (slot_grant & slot_req) == 7'h00)
		else $error("beat longer than one cycle");
	beat_release_a: assert property (bus_valid |-> ##2 slot_grant == 7'h00)
		else $error("grant not released after beat");
	rr_next_a: assert property ($rose(|slot_grant) && ($past(slot_req) & ~last_ff & 7'h1f) != 7'h00
		|-> (slot_grant & last_ff) == 7'h00) else $error("same owner twice while others wait");
endmodule // bra_properties

// [test/backplane_round_robin_arbiter_tb.sv]
// self-checking bench: arbiter with three masters on slots 1, 3 and 6
// assumes the design files under core/ are compiled first
`timescale 1ns/10ps
module backplane_round_robin_arbiter_tb;
	typedef struct {logic [2:0] mask; logic small_sel; int n; logic [8:0] ord;} bra_row_t;
	localparam logic [8:0] SLOTS = {3'h6, 3'h3, 3'h1};
	logic       core_clk    = 1'b0;
	logic       rst_n       = 1'b0;
	logic       small_sel   = 1'b0;
	logic [2:0] cmd_v       = 3'h0;
	logic [2:0] done;
	logic       busy_ff;
	logic [2:0] owner_ff;
	int         num_errors  = 0;
	int         comparisons = 0;
	bra_row_t   rows [6];
	bra_bus_if  bus ();
	bra_bus_if  m_if [3] ();
	// ========================================
	// design and checker
	for (genvar i = 0; i < 3; i++) begin : g_m
		assign m_if[i].slot_grant = bus.slot_grant;
		bra_master #(.SLOT(SLOTS[3*i+:3])) u_bra_master (.core_clk (core_clk), .rst_n (rst_n),
			.cmd_valid (cmd_v[i]), .cmd_addr ({29'h0aa5, SLOTS[3*i+:3]}), .cmd_space (4'h5),
			.cmd_data ({61'h0, SLOTS[3*i+:3]}), .cmd_check (8'h3c), .cmd_tid (8'h0b),
			.cmd_ttype (5'h11), .cmd_done_ff (done[i]), .bus (m_if[i].master));
	end
	// each master drives zero outside its own slot and beat, so or-ing merges them
	always_comb begin
		bus.slot_req = m_if[0].slot_req | m_if[1].slot_req | m_if[2].slot_req;
		bus.bus_valid = m_if[0].bus_valid | m_if[1].bus_valid | m_if[2].bus_valid;
		bus.bus_address_lines = m_if[0].bus_address_lines | m_if[1].bus_address_lines
			| m_if[2].bus_address_lines;
		bus.space_select_lines = m_if[0].space_select_lines | m_if[1].space_select_lines
			| m_if[2].space_select_lines;
		bus.bus_data_lines = m_if[0].bus_data_lines | m_if[1].bus_data_lines
			| m_if[2].bus_data_lines;
		bus.check_byte_lines = m_if[0].check_byte_lines | m_if[1].check_byte_lines
			| m_if[2].check_byte_lines;
		bus.transaction_id_lines = m_if[0].transaction_id_lines
			| m_if[1].transaction_id_lines | m_if[2].transaction_id_lines;
		bus.transaction_type_lines = m_if[0].transaction_type_lines
			| m_if[1].transaction_type_lines | m_if[2].transaction_type_lines;
	end
	bra_arbiter u_bra_arbiter (.core_clk (core_clk), .rst_n (rst_n), .small_chassis (small_sel),
		.bus (bus.arbiter), .busy_ff (busy_ff), .owner_ff (owner_ff));
	bra_properties u_bra_properties (.core_clk (core_clk), .rst_n (rst_n),
		.slot_req (bus.slot_req), .slot_grant (bus.slot_grant), .bus_valid (bus.bus_valid));
	always #10 core_clk = ~core_clk;
	// ========================================
	// tasks
	task automatic check(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask
	task automatic beat(input logic [2:0] s);
		int w;
		w = 0;
		while (bus.bus_valid !== 1'b1 && w < 40) begin
			@(negedge core_clk);
			w++;
		end
		check(bus.slot_grant === (7'h01 << s), "grant");
		check(w < 40, "no beat");
		check(bus.bus_address_lines === {29'h0aa5, s}, "address");
		check(bus.space_select_lines === 4'h5, "space");
		check(bus.bus_data_lines === {61'h0, s}, "data");
		check(bus.check_byte_lines === 8'h3c, "check byte");
		check(bus.transaction_id_lines === 8'h0b, "id");
		check(bus.transaction_type_lines === 5'h11, "type");
		check(owner_ff === s && busy_ff === 1'b1, "owner");
		@(negedge core_clk);
		check(done[s/3] === 1'b1, "done");
		check(bus.bus_data_lines === 64'h0, "data idle");
	endtask
	task automatic go(input bra_row_t r);
		@(posedge core_clk);
		#2;
		small_sel = r.small_sel;
		cmd_v = r.mask;
		@(posedge core_clk);
		#2;
		cmd_v = 3'h0;
		@(negedge core_clk);
		for (int k = 0; k < r.n; k++)
			beat(r.ord[3*k+:3]);
		repeat (6) begin
			@(negedge core_clk);
			check(bus.bus_valid === 1'b0, "extra beat");
			check((bus.slot_req & 7'h35) === 7'h00, "slave request");
		end
		$display("row done at %0t", $time);
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ========================================
	// sequence
	initial begin
		// slot 6 waits masked in row 2 and is served in row 3
		rows = '{'{3'h3, 1'b0, 2, 9'h019}, '{3'h7, 1'b0, 3, 9'h0ce}, '{3'h5, 1'b1, 1, 9'h001},
			'{3'h0, 1'b0, 1, 9'h006}, '{3'h7, 1'b0, 3, 9'h199}, '{3'h1, 1'b0, 1, 9'h001}};
		repeat (5) @(posedge core_clk);
		#2;
		rst_n = 1'b1;
		for (int r = 0; r < 6; r++)
			go(rows[r]);
		// reset while slot 3 owns; pointer must restart at slot 0
		@(posedge core_clk);
		#2;
		cmd_v = 3'h7;
		repeat (2) @(posedge core_clk);
		#2;
		cmd_v = 3'h0;
		rst_n = 1'b0;
		#1;
		check(bus.slot_grant === 7'h00 && busy_ff === 1'b0, "grant in reset");
		check(owner_ff === 3'h0 && bus.slot_req === 7'h00, "owner in reset");
		@(posedge core_clk);
		#2;
		rst_n = 1'b1;
		go(rows[4]);
		results;
	end
	initial begin
		#50000;
		num_errors++;
		results;
	end
endmodule // backplane_round_robin_arbiter_tb
